// [include/nfc_pkg.sv]
// Constants and types for the NAND flash host controller
// Overview of operation
// - A command byte is latched by write strobe rise while command latch is high.
// - An address byte is latched by write strobe rise while address latch is high.
// - Address is four cycles: column low, column high nibble, row low, row high.
// - Data in: latches low, select low, read strobe high, guard high; the guard pin only follows CTRL bit 0, which reset clears.
// - While selected during read busy, keep write and read strobes high; the controller still sends 70, FF and poll steps while busy.
// - Page read is 00, address cycles, then 30.
// - Column change in output is 05, column cycles, then E0.
// - Program is 80, address, data, then 10 normal or 15 cached.
// - Block erase is 60, row address cycles, then D0.
// - Host ends a cached program with 80 then 10.
// - After 80 then 15 ending, poll status page-buffer ready, then send FF.
// - Host never drives the bus while the device outputs data.
`default_nettype none
package nfc_pkg;
  localparam int CLK_MHZ = 10;
  localparam int T_WP_NS  = 12;
  localparam int T_WH_NS  = 10;
  localparam int T_WHR_NS = 60;
  localparam int T_WB_NS  = 100;
  localparam int T_RP_NS  = 12;
  localparam int T_REA_NS = 20;
  localparam int T_REH_NS = 10;

  function automatic int nfc_ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : nfc_ns2cyc

  function automatic int nfc_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : nfc_max

  localparam int T_WLOW_CYC  = nfc_ns2cyc(T_WP_NS);
  localparam int T_WHIGH_CYC = nfc_max(nfc_ns2cyc(T_WH_NS),
                                       nfc_ns2cyc(T_WHR_NS));
  localparam int T_WB_CYC    = nfc_ns2cyc(T_WB_NS);
  localparam int T_RLOW_CYC  = nfc_max(nfc_ns2cyc(T_RP_NS),
                                       nfc_ns2cyc(T_REA_NS));
  localparam int T_RHIGH_CYC = nfc_ns2cyc(T_REH_NS);

  localparam int PAGE_BYTES      = 2176;
  localparam int MAIN_BYTES      = 2048;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int COL_W           = 12;
  localparam int ROW_W           = 16;
  localparam int PAGE_IDX_W      = 6;

  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STEP  = 8'h04;
  localparam logic [7:0] REG_COL   = 8'h08;
  localparam logic [7:0] REG_ROW   = 8'h0C;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_PAGE  = 8'h18;

  localparam int CTRL_GUARD_BIT = 0;
  localparam int CTRL_SEL_BIT   = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int STEP_KIND_LSB = 8;
  localparam int PAGE_BLK_LSB  = 16;

  localparam int SB_FAIL_CUR  = 0;
  localparam int SB_FAIL_PREV = 1;
  localparam int SB_PB_READY  = 5;
  localparam int SB_DC_READY  = 6;

  localparam logic [7:0] CMD_READ       = 8'h00;
  localparam logic [7:0] CMD_READ_GO    = 8'h30;
  localparam logic [7:0] CMD_COL_OUT    = 8'h05;
  localparam logic [7:0] CMD_COL_OUT_GO = 8'hE0;
  localparam logic [7:0] CMD_CACHE_RD   = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
  localparam logic [7:0] CMD_PROG       = 8'h80;
  localparam logic [7:0] CMD_PROG_GO    = 8'h10;
  localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
  localparam logic [7:0] CMD_COL_IN     = 8'h85;
  localparam logic [7:0] CMD_COPY_RD    = 8'h3A;
  localparam logic [7:0] CMD_COPY_PROG  = 8'h8C;
  localparam logic [7:0] CMD_ERASE      = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO   = 8'hD0;
  localparam logic [7:0] CMD_ID         = 8'h90;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_RESET      = 8'hFF;

  typedef enum logic [2:0] {
    KIND_CMD      = 3'h0,
    KIND_ADDR4    = 3'h1,
    KIND_ADDR_COL = 3'h2,
    KIND_ADDR_ROW = 3'h3,
    KIND_DIN      = 3'h4,
    KIND_DOUT     = 3'h5,
    KIND_WAIT     = 3'h6,
    KIND_POLL     = 3'h7
  } nfc_kind_e;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_CHECK  = 8'h02,
    ST_WLOW   = 8'h04,
    ST_WHIGH  = 8'h08,
    ST_RLOW   = 8'h10,
    ST_RHIGH  = 8'h20,
    ST_SETTLE = 8'h40,
    ST_WAIT   = 8'h80
  } nfc_state_e;
endpackage : nfc_pkg
`default_nettype wire

// [rtl/nfc_cycle_timer.sv]
// Down counter timing each strobe phase
`default_nettype none
module nfc_cycle_timer #(
  parameter int W = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  output logic              o_done
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (i_load) begin
      nxt_cnt = i_value;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_done = (cnt_ff == '0);
endmodule : nfc_cycle_timer
`default_nettype wire

// [rtl/nfc_ahb_slave.sv]
// AHB-Lite slave front end for the controller registers
`default_nettype none
module nfc_ahb_slave (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_step_ok,
  output logic [7:0]       o_rd_addr,
  output logic             o_wr_stb,
  output logic [7:0]       o_wr_addr,
  output logic [31:0]      o_wdata,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp
);
  logic        wpend_ff;
  logic        nxt_wpend;
  logic [7:0]  waddr_ff;
  logic [7:0]  nxt_waddr;
  logic        hready_ff;
  logic        nxt_hready;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic        take;
  logic        hit;

  assign take      = i_hsel && i_htrans[1] && i_hready;
  assign hit       = (i_haddr[31:8] == 24'h000000) && (i_hsize == 3'h2);
  assign o_rd_addr = i_haddr[7:0];
  assign o_wr_stb  = wpend_ff &&
                     ((waddr_ff != nfc_pkg::REG_STEP) || i_step_ok);
  assign o_wr_addr = waddr_ff;
  assign o_wdata   = i_hwdata;

  always_comb begin
    nxt_wpend  = wpend_ff;
    nxt_waddr  = waddr_ff;
    nxt_hready = hready_ff;
    nxt_hrdata = hrdata_ff;
    if (o_wr_stb) begin
      nxt_wpend  = 1'b0;
      nxt_hready = 1'b1;
    end
    if (take && i_hwrite && hit) begin
      nxt_wpend  = 1'b1;
      nxt_waddr  = i_haddr[7:0];
      nxt_hready = 1'b0;
    end else if (take && !i_hwrite) begin
      nxt_hrdata = hit ? i_rdata : 32'h00000000;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wpend_ff  <= 1'b0;
      waddr_ff  <= 8'h00;
      hready_ff <= 1'b1;
      hrdata_ff <= 32'h00000000;
    end else begin
      wpend_ff  <= nxt_wpend;
      waddr_ff  <= nxt_waddr;
      hready_ff <= nxt_hready;
      hrdata_ff <= nxt_hrdata;
    end
  end

  assign o_hreadyout = hready_ff;
  assign o_hrdata    = hrdata_ff;
  assign o_hresp     = 1'b0;
endmodule : nfc_ahb_slave
`default_nettype wire

// [rtl/nfc_host_ctrl.sv]
// NAND flash host controller: register file, step engine and pin drive
`default_nettype none
module nfc_host_ctrl #(
  parameter int P_COL_W      = nfc_pkg::COL_W,
  parameter int P_ROW_W      = nfc_pkg::ROW_W,
  parameter int P_PAGE_BYTES = nfc_pkg::PAGE_BYTES
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_nand_ce_n,
  output logic             o_nand_cle,
  output logic             o_nand_ale,
  output logic             o_nand_we_n,
  output logic             o_read_strobe_low,
  output logic             o_prog_guard_n,
  output logic [7:0]       o_nand_io_out,
  output logic             o_nand_io_oe,
  input  wire logic [7:0]  i_nand_io_in,
  input  wire logic        i_ready_busy_out
);
  localparam int TW = 4;

  if (P_COL_W != 12 || P_ROW_W != 16) begin : g_bad_width
    $error("Address widths must match the four-cycle address map");
  end
  if (P_PAGE_BYTES < 1 || P_PAGE_BYTES > (1 << P_COL_W)) begin : g_bad_page
    $error("Page size does not fit the column index");
  end
  if (nfc_pkg::T_WHIGH_CYC > 15 || nfc_pkg::T_RLOW_CYC > 15 ||
      nfc_pkg::T_WB_CYC > 15) begin : g_bad_timer
    $error("Phase timing exceeds the phase timer");
  end

  localparam logic [TW-1:0] LD_WLOW  = TW'(nfc_pkg::T_WLOW_CYC - 1);
  localparam logic [TW-1:0] LD_WHIGH = TW'(nfc_pkg::T_WHIGH_CYC - 1);
  localparam logic [TW-1:0] LD_WB    = TW'(nfc_pkg::T_WB_CYC - 1);
  localparam logic [TW-1:0] LD_RLOW  = TW'(nfc_pkg::T_RLOW_CYC - 1);
  localparam logic [TW-1:0] LD_RHIGH = TW'(nfc_pkg::T_RHIGH_CYC - 1);
  localparam logic [11:0] COL_LAST = 12'(P_PAGE_BYTES - 1);

  logic [7:0]  rd_addr;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        step_go;
  logic        tmr_load;
  logic [TW-1:0] tmr_val;
  logic        tmr_done;

  nfc_pkg::nfc_state_e state_ff;
  nfc_pkg::nfc_state_e nxt_state;
  nfc_pkg::nfc_kind_e  kind_ff;
  nfc_pkg::nfc_kind_e  nxt_kind;
  logic [7:0]  byte_ff;
  logic [7:0]  nxt_byte;
  logic [1:0]  idx_ff;
  logic [1:0]  nxt_idx;
  logic [1:0]  end_ff;
  logic [1:0]  nxt_end;
  logic [11:0] col_ff;
  logic [11:0] nxt_col;
  logic [7:0]  rbyte_ff;
  logic [7:0]  nxt_rbyte;
  logic [7:0]  sbyte_ff;
  logic [7:0]  nxt_sbyte;
  logic        cpend_ff;
  logic        nxt_cpend;
  logic        ce_n_ff;
  logic        nxt_ce_n;
  logic        cle_ff;
  logic        nxt_cle;
  logic        ale_ff;
  logic        nxt_ale;
  logic        we_n_ff;
  logic        nxt_we_n;
  logic        re_n_ff;
  logic        nxt_re_n;
  logic [7:0]  io_ff;
  logic [7:0]  nxt_io;
  logic        oe_ff;
  logic        nxt_oe;
  logic [1:0]  ctrl_ff;
  logic [1:0]  nxt_ctrl;
  logic [15:0] row_ff;
  logic [15:0] nxt_row;
  logic        guard_n_ff;
  logic        need_ready;

  nfc_ahb_slave u_bus (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hsize     (i_hsize),
    .i_hready    (i_hready),
    .i_hwdata    (i_hwdata),
    .i_rdata     (rdata),
    .i_step_ok   (state_ff == nfc_pkg::ST_IDLE),
    .o_rd_addr   (rd_addr),
    .o_wr_stb    (wr_stb),
    .o_wr_addr   (wr_addr),
    .o_wdata     (wdata),
    .o_hrdata    (o_hrdata),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp)
  );

  nfc_cycle_timer #(
    .W (TW)
  ) u_tmr (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_load    (tmr_load),
    .i_value   (tmr_val),
    .o_done    (tmr_done)
  );

  // Address byte for a given cycle of the four-cycle map
  function automatic logic [7:0] addr_byte(input logic [1:0]  idx,
                                           input logic [11:0] col,
                                           input logic [15:0] row);
    case (idx)
      2'h0:    return col[7:0];
      2'h1:    return {4'h0, col[11:8]};
      2'h2:    return row[7:0];
      default: return row[15:8];
    endcase
  endfunction : addr_byte

  assign step_go = wr_stb && (wr_addr == nfc_pkg::REG_STEP);

  // Only status read and reset may go out while the device is busy
  assign need_ready = !((kind_ff == nfc_pkg::KIND_CMD) &&
                        ((byte_ff == nfc_pkg::CMD_STATUS) ||
                         (byte_ff == nfc_pkg::CMD_RESET))) &&
                      (kind_ff != nfc_pkg::KIND_POLL) &&
                      (kind_ff != nfc_pkg::KIND_WAIT);

  // Control and row registers
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_row  = row_ff;
    if (wr_stb && wr_addr == nfc_pkg::REG_CTRL) begin
      nxt_ctrl = wdata[1:0];
    end
    if (wr_stb && wr_addr == nfc_pkg::REG_ROW) begin
      nxt_row = wdata[15:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_ff    <= nfc_pkg::CTRL_RST;
      row_ff     <= 16'h0000;
      guard_n_ff <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      row_ff     <= nxt_row;
      guard_n_ff <= nxt_ctrl[nfc_pkg::CTRL_GUARD_BIT];
    end
  end

  // Step engine and pin drive
  always_comb begin
    nxt_state = state_ff;
    nxt_kind  = kind_ff;
    nxt_byte  = byte_ff;
    nxt_idx   = idx_ff;
    nxt_end   = end_ff;
    nxt_col   = col_ff;
    nxt_rbyte = rbyte_ff;
    nxt_sbyte = sbyte_ff;
    nxt_cpend = cpend_ff;
    nxt_cle   = cle_ff;
    nxt_ale   = ale_ff;
    nxt_we_n  = we_n_ff;
    nxt_re_n  = re_n_ff;
    nxt_io    = io_ff;
    nxt_oe    = oe_ff;
    tmr_load  = 1'b0;
    tmr_val   = '0;
    case (state_ff)
      nfc_pkg::ST_IDLE: begin
        if (step_go) begin
          nxt_kind  = nfc_pkg::nfc_kind_e'(wdata[nfc_pkg::STEP_KIND_LSB +: 3]);
          nxt_byte  = wdata[7:0];
          nxt_state = nfc_pkg::ST_CHECK;
          case (nfc_pkg::nfc_kind_e'(wdata[nfc_pkg::STEP_KIND_LSB +: 3]))
            nfc_pkg::KIND_ADDR_COL: begin
              nxt_idx = 2'h0;
              nxt_end = 2'h1;
            end
            nfc_pkg::KIND_ADDR_ROW: begin
              nxt_idx = 2'h2;
              nxt_end = 2'h3;
            end
            default: begin
              nxt_idx = 2'h0;
              nxt_end = 2'h3;
            end
          endcase
        end
      end
      nfc_pkg::ST_CHECK: begin
        if (need_ready && !i_ready_busy_out) begin
          nxt_state = nfc_pkg::ST_CHECK;
        end else begin
          tmr_load = 1'b1;
          tmr_val  = LD_WLOW;
          nxt_oe   = 1'b1;
          nxt_we_n = 1'b0;
          nxt_state = nfc_pkg::ST_WLOW;
          case (kind_ff)
            nfc_pkg::KIND_CMD: begin
              nxt_cle = 1'b1;
              nxt_io  = byte_ff;
            end
            nfc_pkg::KIND_POLL: begin
              nxt_cle = 1'b1;
              nxt_io  = nfc_pkg::CMD_STATUS;
            end
            nfc_pkg::KIND_DIN: begin
              nxt_io = byte_ff;
            end
            nfc_pkg::KIND_DOUT: begin
              nxt_oe    = 1'b0;
              nxt_we_n  = 1'b1;
              nxt_re_n  = 1'b0;
              tmr_val   = LD_RLOW;
              nxt_state = nfc_pkg::ST_RLOW;
            end
            nfc_pkg::KIND_WAIT: begin
              tmr_load  = 1'b0;
              nxt_oe    = 1'b0;
              nxt_we_n  = 1'b1;
              nxt_state = nfc_pkg::ST_WAIT;
            end
            default: begin
              nxt_ale = 1'b1;
              nxt_io  = addr_byte(idx_ff, col_ff, row_ff);
            end
          endcase
        end
      end
      nfc_pkg::ST_WLOW: begin
        if (tmr_done) begin
          nxt_we_n  = 1'b1;
          tmr_load  = 1'b1;
          tmr_val   = LD_WHIGH;
          nxt_state = nfc_pkg::ST_WHIGH;
        end
      end
      nfc_pkg::ST_WHIGH: begin
        if (tmr_done) begin
          if (ale_ff && idx_ff != end_ff) begin
            nxt_idx   = idx_ff + 2'h1;
            nxt_io    = addr_byte(idx_ff + 2'h1, col_ff, row_ff);
            nxt_we_n  = 1'b0;
            tmr_load  = 1'b1;
            tmr_val   = LD_WLOW;
            nxt_state = nfc_pkg::ST_WLOW;
          end else begin
            nxt_cle   = 1'b0;
            nxt_ale   = 1'b0;
            nxt_oe    = 1'b0;
            nxt_state = nfc_pkg::ST_IDLE;
            case (kind_ff)
              nfc_pkg::KIND_CMD: begin
                if (byte_ff == nfc_pkg::CMD_CACHE_RD) begin
                  nxt_col = 12'h000;
                end
                if (byte_ff == nfc_pkg::CMD_PROG_CACHE) begin
                  nxt_cpend = 1'b1;
                end else if (byte_ff == nfc_pkg::CMD_PROG_GO ||
                             byte_ff == nfc_pkg::CMD_RESET) begin
                  nxt_cpend = 1'b0;
                end
                tmr_load  = 1'b1;
                tmr_val   = LD_WB;
                nxt_state = nfc_pkg::ST_SETTLE;
              end
              nfc_pkg::KIND_POLL: begin
                nxt_re_n  = 1'b0;
                tmr_load  = 1'b1;
                tmr_val   = LD_RLOW;
                nxt_state = nfc_pkg::ST_RLOW;
              end
              nfc_pkg::KIND_DIN: begin
                nxt_col = (col_ff == COL_LAST) ? 12'h000 : col_ff + 12'h001;
              end
              default: begin
                nxt_state = nfc_pkg::ST_IDLE;
              end
            endcase
          end
        end
      end
      nfc_pkg::ST_RLOW: begin
        if (tmr_done) begin
          nxt_re_n  = 1'b1;
          tmr_load  = 1'b1;
          tmr_val   = LD_RHIGH;
          nxt_state = nfc_pkg::ST_RHIGH;
          if (kind_ff == nfc_pkg::KIND_POLL) begin
            nxt_sbyte = i_nand_io_in;
          end else begin
            nxt_rbyte = i_nand_io_in;
            nxt_col = (col_ff == COL_LAST) ? 12'h000 : col_ff + 12'h001;
          end
        end
      end
      nfc_pkg::ST_RHIGH: begin
        if (tmr_done) begin
          if (kind_ff == nfc_pkg::KIND_POLL &&
              !sbyte_ff[nfc_pkg::SB_PB_READY]) begin
            nxt_re_n  = 1'b0;
            tmr_load  = 1'b1;
            tmr_val   = LD_RLOW;
            nxt_state = nfc_pkg::ST_RLOW;
          end else begin
            nxt_state = nfc_pkg::ST_IDLE;
          end
        end
      end
      nfc_pkg::ST_SETTLE: begin
        if (tmr_done) begin
          nxt_state = nfc_pkg::ST_IDLE;
        end
      end
      nfc_pkg::ST_WAIT: begin
        if (i_ready_busy_out) begin
          nxt_state = nfc_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = nfc_pkg::ST_IDLE;
      end
    endcase
    if (wr_stb && wr_addr == nfc_pkg::REG_COL) begin
      nxt_col = wdata[11:0];
    end
    nxt_ce_n = !(nxt_ctrl[nfc_pkg::CTRL_SEL_BIT] ||
                 (nxt_state != nfc_pkg::ST_IDLE));
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_ff <= nfc_pkg::ST_IDLE;
      kind_ff  <= nfc_pkg::KIND_CMD;
      byte_ff  <= 8'h00;
      idx_ff   <= 2'h0;
      end_ff   <= 2'h0;
      col_ff   <= 12'h000;
      rbyte_ff <= 8'h00;
      sbyte_ff <= 8'h00;
      cpend_ff <= 1'b0;
      ce_n_ff  <= 1'b1;
      cle_ff   <= 1'b0;
      ale_ff   <= 1'b0;
      we_n_ff  <= 1'b1;
      re_n_ff  <= 1'b1;
      io_ff    <= 8'h00;
      oe_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      kind_ff  <= nxt_kind;
      byte_ff  <= nxt_byte;
      idx_ff   <= nxt_idx;
      end_ff   <= nxt_end;
      col_ff   <= nxt_col;
      rbyte_ff <= nxt_rbyte;
      sbyte_ff <= nxt_sbyte;
      cpend_ff <= nxt_cpend;
      ce_n_ff  <= nxt_ce_n;
      cle_ff   <= nxt_cle;
      ale_ff   <= nxt_ale;
      we_n_ff  <= nxt_we_n;
      re_n_ff  <= nxt_re_n;
      io_ff    <= nxt_io;
      oe_ff    <= nxt_oe;
    end
  end

  // Register read mux
  always_comb begin
    case (rd_addr)
      nfc_pkg::REG_CTRL:  rdata = {30'h00000000, ctrl_ff};
      nfc_pkg::REG_COL:   rdata = {20'h00000, col_ff};
      nfc_pkg::REG_ROW:   rdata = {16'h0000, row_ff};
      nfc_pkg::REG_RDATA: rdata = {24'h000000, rbyte_ff};
      nfc_pkg::REG_STAT: begin
        rdata = {16'h0000, sbyte_ff, 5'h00, cpend_ff, i_ready_busy_out,
                 (state_ff != nfc_pkg::ST_IDLE)};
      end
      nfc_pkg::REG_PAGE: begin
        rdata = {6'h00, row_ff[15:nfc_pkg::PAGE_IDX_W], 10'h000,
                 row_ff[nfc_pkg::PAGE_IDX_W-1:0]};
      end
      default:            rdata = 32'h00000000;
    endcase
  end

  assign o_nand_ce_n       = ce_n_ff;
  assign o_nand_cle        = cle_ff;
  assign o_nand_ale        = ale_ff;
  assign o_nand_we_n       = we_n_ff;
  assign o_read_strobe_low = re_n_ff;
  assign o_prog_guard_n    = guard_n_ff;
  assign o_nand_io_out     = io_ff;
  assign o_nand_io_oe      = oe_ff;
endmodule : nfc_host_ctrl
`default_nettype wire

// [verif/nfc_host_ctrl_properties.sv]
// Pin protocol checker for the flash host controller
`default_nettype none
module nfc_host_ctrl_properties (
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_ready_busy_out,
  input wire logic       o_nand_ce_n,
  input wire logic       o_nand_cle,
  input wire logic       o_nand_ale,
  input wire logic       o_nand_we_n,
  input wire logic       o_read_strobe_low,
  input wire logic       o_prog_guard_n,
  input wire logic       o_nand_io_oe,
  input wire logic [7:0] o_nand_io_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence we_pulse_s;
    !o_nand_we_n ##1 o_nand_we_n;
  endsequence
  cmd_latch_a: assert property ($rose(o_nand_we_n) && o_nand_cle
    |-> o_nand_io_oe && !o_nand_ale) else $error("bad command latch");
  addr_latch_a: assert property ($rose(o_nand_we_n) && o_nand_ale
    |-> o_nand_io_oe && !o_nand_cle) else $error("bad address latch");
  we_pulse_a: assert property ($fell(o_nand_we_n) |-> we_pulse_s)
    else $error("write strobe too long");
  rd_pulse_a: assert property ($fell(o_read_strobe_low)
    |=> o_read_strobe_low) else $error("read strobe too long");
  no_drive_a: assert property (!o_read_strobe_low |-> !o_nand_io_oe
    && o_nand_we_n && !o_nand_cle && !o_nand_ale) else $error("bus clash");
  select_a: assert property (!o_nand_we_n || !o_read_strobe_low
    |-> !o_nand_ce_n) else $error("strobe while deselected");
  busy_cmd_a: assert property (!o_nand_we_n && !i_ready_busy_out
    |-> o_nand_cle && o_nand_io_out inside {8'h70, 8'hFF})
    else $error("write while busy");
  reset_idle_a: assert property ($fell(i_sys_rst) |-> o_nand_ce_n
    && o_nand_we_n && o_read_strobe_low && !o_nand_io_oe
    && !o_prog_guard_n) else $error("pins not idle after reset");
endmodule : nfc_host_ctrl_properties
bind nfc_host_ctrl nfc_host_ctrl_properties u_props (.*);
`default_nettype wire

// [verif/nfc_flash_model.sv]
// Behavioural flash device answering the controller pins
`default_nettype none
module nfc_flash_model (
  input  wire logic       i_ce_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_re_n,
  input  wire logic       i_guard_n,
  input  wire logic [7:0] i_io,
  output logic [7:0]      o_io,
  output logic            o_rb
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID_BYTE = 8'hC3; // Arbitrary identification value
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  q   = 8'h00;
  logic [11:0] col = 12'h000;
  int          n   = 0;
  initial o_rb = 1'b1;
  assign o_io = i_re_n ? ~q : q;
  always @(posedge i_we_n) if (!i_ce_n && i_cle) begin
    if ((o_rb || i_io inside {8'h70, 8'hFF}) && i_io inside {8'h00,
        8'h05, 8'h10, 8'h15, 8'h30, 8'h31, 8'h3A, 8'h3F, 8'h60, 8'h70,
        8'h80, 8'h85, 8'h8C, 8'h90, 8'hD0, 8'hE0, 8'hFF}) begin
      cmd = i_io;
      n = 0;
      if (i_io == 8'h31) col = 12'h000;
      if (i_io inside {8'h30, 8'h31, 8'h3A, 8'h3F} || (i_guard_n
          && i_io inside {8'h10, 8'h15, 8'hD0})) begin
        o_rb <= #50 1'b0;
        o_rb <= #2050 1'b1;
      end
    end
  end else if (!i_ce_n && i_ale) begin
    if (n == 0) col[7:0] = i_io;
    if (n == 1) col[11:8] = i_io[3:0];
    n++;
  end
  always @(negedge i_re_n) if (!i_ce_n) begin
    q = cmd == 8'h70 ? {1'b0, o_rb, o_rb, 5'h00}
      : cmd == 8'h90 ? ID_BYTE : col[7:0];
    col = (col == 12'h87F) ? 12'h000 : col + 12'h001;
  end
endmodule : nfc_flash_model
`default_nettype wire

// [verif/nfc_host_ctrl_bench.sv]
// Self-checking bench for the flash host controller
`default_nettype none
module nfc_host_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk, i_sys_rst, i_hsel, i_hwrite, i_hready;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, r;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  logic        o_hreadyout, o_hresp, o_nand_ce_n, o_nand_cle;
  logic        o_nand_ale, o_nand_we_n, o_read_strobe_low;
  logic        o_prog_guard_n, o_nand_io_oe, i_ready_busy_out;
  logic [7:0]  o_nand_io_out, i_nand_io_in, flash_io;
  int          mismatches = 0;
  int          total_checks = 0;
  logic [40:0] rows [36] = '{
    41'h0_10_00000002, 41'h1_04_00000060, 41'h1_04_00000300,
    41'h1_04_000000D0, 41'h0_10_00000002, 41'h1_00_00000001,
    41'h0_00_00000001, 41'h1_04_00000060, 41'h1_04_00000300,
    41'h1_04_000000D0, 41'h0_10_00000000, 41'h1_04_00000600,
    41'h1_08_00000005, 41'h1_0C_00000041, 41'h0_18_00010001,
    41'h1_04_00000000, 41'h1_04_00000100, 41'h1_04_00000030,
    41'h1_04_00000600, 41'h1_04_00000500, 41'h0_14_00000005,
    41'h0_08_00000006, 41'h1_04_00000031, 41'h0_08_00000000,
    41'h1_04_00000700, 41'h0_10_00006002, 41'h1_40_12345678,
    41'h1_04_0000002B, 41'h1_04_00000500, 41'h0_14_00000060,
    41'h1_04_00000080, 41'h1_04_00000200, 41'h1_04_000004AB,
    41'h0_08_00000002, 41'h1_04_00000015, 41'h0_10_00006004};
  assign i_hsize = 3'h2;
  assign i_hready = o_hreadyout;
  assign i_nand_io_in = o_nand_io_oe ? o_nand_io_out : flash_io;
  nfc_host_ctrl dut (.*);
  nfc_flash_model flash (
    .i_ce_n    (o_nand_ce_n),
    .i_cle     (o_nand_cle),
    .i_ale     (o_nand_ale),
    .i_we_n    (o_nand_we_n),
    .i_re_n    (o_read_strobe_low),
    .i_guard_n (o_prog_guard_n),
    .i_io      (i_nand_io_in),
    .o_io      (flash_io),
    .o_rb      (i_ready_busy_out)
  );
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    i_hsel   <= 1'b1;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    i_haddr  <= {24'h000000, a};
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    r = o_hrdata;
  endtask : xfer
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #2000000;
    mismatches++;
    complete_run();
  end
  initial begin
    i_sys_rst = 1'b1;
    i_hsel = 1'b0;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_haddr = 32'h0;
    i_hwdata = 32'h0;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    foreach (rows[i]) begin
      do xfer(1'b0, 8'h10, 32'h0); while (r[0] !== 1'b0);
      xfer(rows[i][40], rows[i][39:32], rows[i][31:0]);
      if (!rows[i][40]) check(r, rows[i][31:0]);
      $display("row %0d done", i);
    end
    xfer(1'b0, 8'h40, 32'h0);
    check(r, 32'h0);
    check({31'h0, o_nand_ce_n}, 32'h1);
    check({31'h0, o_prog_guard_n}, 32'h1);
    check({31'h0, o_hresp}, 32'h0);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    xfer(1'b0, 8'h00, 32'h0);
    check(r, 32'h0);
    check({31'h0, o_prog_guard_n}, 32'h0);
    $display("reset test done");
    complete_run();
  end
endmodule : nfc_host_ctrl_bench
`default_nettype wire
